// File: rtl/serial_port_pkg.sv
package serial_port_pkg;

	// Register byte offsets on the bus
	localparam logic [31:0] OFS_MODE   = 32'h0000_0000;
	localparam logic [31:0] OFS_BRATE  = 32'h0000_0004;
	localparam logic [31:0] OFS_CTRL   = 32'h0000_0008;
	localparam logic [31:0] OFS_TXDATA = 32'h0000_000C;
	localparam logic [31:0] OFS_STATUS = 32'h0000_0010;
	localparam logic [31:0] OFS_RXDATA = 32'h0000_0014;

	// Internal register indices
	localparam logic [2:0] IDX_MODE   = 3'h0;
	localparam logic [2:0] IDX_BRATE  = 3'h1;
	localparam logic [2:0] IDX_CTRL   = 3'h2;
	localparam logic [2:0] IDX_TXDATA = 3'h3;
	localparam logic [2:0] IDX_STATUS = 3'h4;
	localparam logic [2:0] IDX_RXDATA = 3'h5;

	// ctrl_reg fields
	localparam int CTRL_TX_EMPTY_IRQ_EN = 7;
	localparam int CTRL_RX_IRQ_EN       = 6;
	localparam int CTRL_TX_ENABLE       = 5;
	localparam int CTRL_RX_ENABLE       = 4;
	localparam int CTRL_ADDR_WAIT_EN    = 3;
	localparam int CTRL_TX_DONE_IRQ_EN  = 2;
	localparam int CTRL_CLK_SRC_SEL_HI  = 1;
	localparam int CTRL_CLK_SRC_SEL_LO  = 0;

	// mode_reg fields
	localparam int MODE_SYNC_SEL     = 7;
	localparam int MODE_TWO_STOP     = 3;
	localparam int MODE_ADDR_FRAME   = 2;

	// status_flags_reg fields
	localparam int ST_TX_BUF_EMPTY = 7;
	localparam int ST_RX_BUF_FULL  = 6;
	localparam int ST_OVERRUN_ERR  = 5;
	localparam int ST_FRAMING_ERR  = 4;
	localparam int ST_PARITY_ERR   = 3;
	localparam int ST_TX_COMPLETE  = 2;
	localparam int ST_RX_ADDR_BIT  = 1;
	localparam int ST_TX_ADDR_BIT  = 0;

	// Reset values
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] MODE_RESET   = 8'h00;
	localparam logic [7:0] BRATE_RESET  = 8'hFF;
	localparam logic [7:0] TXDATA_RESET = 8'hFF;
	localparam logic [7:0] RXDATA_RESET = 8'h00;

	// Bit timing: last tick of a bit, mid-bit tick, last data bit
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] TICK_MID  = 4'h7;
	localparam logic [3:0] BIT_LAST  = 4'h7;

	// AHB encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [4:0] {
		TX_IDLE  = 5'h01,
		TX_START = 5'h02,
		TX_DATA  = 5'h04,
		TX_ADDR  = 5'h08,
		TX_STOP  = 5'h10
	} tx_state_t;

	typedef enum logic [4:0] {
		RX_IDLE  = 5'h01,
		RX_START = 5'h02,
		RX_DATA  = 5'h04,
		RX_ADDR  = 5'h08,
		RX_STOP  = 5'h10
	} rx_state_t;

	typedef struct packed {
		logic [7:0]  ctrl_reg;
		logic [7:0]  mode_reg;
		logic [7:0]  brate;
		logic [7:0]  tx_hold_reg;
		logic [7:0]  rx_hold_reg;
		logic        tx_buf_empty;
		logic        rx_buf_full;
		logic        overrun_err;
		logic        framing_err;
		logic        parity_err;
		logic        tx_complete;
		logic        rx_addr_bit;
		logic        tx_addr_bit;
		logic        seen_tx_empty;
		logic        seen_rx_full;
		logic        seen_overrun;
		logic        seen_framing;
		logic        seen_parity;
		logic        wr_pend;
		logic [2:0]  wr_idx;
		logic [31:0] hrdata;
		logic        rxd_s1;
		logic        rxd_s2;
		logic        sck_s1;
		logic        sck_s2;
		logic        sck_d;
		logic [7:0]  pre_cnt;
		logic [3:0]  clk_cnt;
		logic        sck_out;
		tx_state_t   tx_st;
		logic [7:0]  tx_shift_reg;
		logic [3:0]  tx_bit;
		logic [3:0]  tx_tick;
		logic        txd;
		rx_state_t   rx_st;
		logic [7:0]  rx_shift_reg;
		logic [3:0]  rx_bit;
		logic [3:0]  rx_tick;
		logic        rx_mp;
	} port_state_t;

	localparam port_state_t STATE_RESET = '{
		ctrl_reg:     CTRL_RESET,
		mode_reg:     MODE_RESET,
		brate:        BRATE_RESET,
		tx_hold_reg:  TXDATA_RESET,
		rx_hold_reg:  RXDATA_RESET,
		tx_buf_empty: 1'b1,
		tx_complete:  1'b1,
		rxd_s1:       1'b1,
		rxd_s2:       1'b1,
		sck_s1:       1'b1,
		sck_s2:       1'b1,
		sck_d:        1'b1,
		sck_out:      1'b1,
		txd:          1'b1,
		tx_st:        TX_IDLE,
		rx_st:        RX_IDLE,
		default:      '0
	};

endpackage

// File: rtl/serial_port_ctrl.sv
// Function
// - Bit 7 gates transmit-empty interrupt
// - Transmit-empty request drops on flag clear
// - Bit 6 gates receive-full and error interrupts
// - Receive requests drop on flag clear
// - Transmit disabled holds empty flag high
// - Transmission starts after empty flag cleared
// - Receive disable leaves receive flags alone
// - Reception starts on start bit or clock
// - Address wait only async with address frames
// - Address wait blocks transfer, full and error flags
// - Address character ends wait, sets address bit
// - Bit 2 gates transmit-done at last bit
// - Transmit-done drops on flag clear
// - Low select bit honoured only async internal
// - Both selects zero: internal, pin per mode
// - Low select set, high select clear: internal clock driven out
// - High select set: external clock input
// - Async output clock runs at bit rate
// - Control register read/write, cleared on standby
// - Mode bit picks async or sync operation
// - Load into shifter sets empty flag
// - Good character sets receive-full flag
`timescale 1ns/10ps
`default_nettype none

module serial_port_ctrl
	import serial_port_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Power state
	input  wire logic        standby,
	// Serial line
	input  wire logic        rxd,
	output logic             txd,
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe,
	// Interrupt requests
	output logic             tx_empty_irq,
	output logic             rx_full_irq,
	output logic             rx_error_irq,
	output logic             tx_done_irq
);

	port_state_t s;
	port_state_t next_s;

	// Address decode: hit flag and register index
	function automatic logic [3:0] reg_decode(input logic [31:0] a);
		logic [3:0] r;
		r = 4'h0;
		if (a == OFS_MODE)
			r = {1'b1, IDX_MODE};
		else if (a == OFS_BRATE)
			r = {1'b1, IDX_BRATE};
		else if (a == OFS_CTRL)
			r = {1'b1, IDX_CTRL};
		else if (a == OFS_TXDATA)
			r = {1'b1, IDX_TXDATA};
		else if (a == OFS_STATUS)
			r = {1'b1, IDX_STATUS};
		else if (a == OFS_RXDATA)
			r = {1'b1, IDX_RXDATA};
		return r;
	endfunction

	// Read data multiplexer
	function automatic logic [7:0] rd_byte(input port_state_t t, input logic [2:0] idx);
		logic [7:0] b;
		b = 8'h00;
		if (idx == IDX_MODE)
			b = t.mode_reg;
		else if (idx == IDX_BRATE)
			b = t.brate;
		else if (idx == IDX_CTRL)
			b = t.ctrl_reg;
		else if (idx == IDX_TXDATA)
			b = t.tx_hold_reg;
		else if (idx == IDX_STATUS)
			b = {t.tx_buf_empty, t.rx_buf_full, t.overrun_err, t.framing_err,
				t.parity_err, t.tx_complete, t.rx_addr_bit, t.tx_addr_bit};
		else if (idx == IDX_RXDATA)
			b = t.rx_hold_reg;
		return b;
	endfunction

	// End of a received character: address wait, overrun, framing, full
	function automatic port_state_t rx_finish(input port_state_t t, input logic [7:0] data,
		input logic stop_ok, input logic mpv, input logic mp_on);
		logic skip;
		skip = mp_on && t.ctrl_reg[CTRL_ADDR_WAIT_EN] && !mpv;
		if (mp_on)
			t.rx_addr_bit = mpv;
		if (mp_on && mpv)
			t.ctrl_reg[CTRL_ADDR_WAIT_EN] = 1'b0;
		if (!skip)
		begin
			if (t.rx_buf_full)
				t.overrun_err = 1'b1;
			else if (!stop_ok)
			begin
				t.framing_err = 1'b1;
				t.rx_hold_reg = data;
			end
			else
			begin
				t.rx_hold_reg = data;
				t.rx_buf_full = 1'b1;
			end
		end
		return t;
	endfunction

	// Next-state logic
	always_comb
	begin
		logic [3:0] dec;
		logic       acc;
		logic       is_async;
		logic       ext_clk;
		logic       rise;
		logic       fall;
		logic       int_tick;
		logic       clk_run;
		logic       tick;
		logic       shift_ev;
		logic       sample_ev;
		logic       tx_step;
		logic       rx_samp;
		logic       mp_on;
		logic       blocked;
		logic [7:0] rx_byte;
		dec       = reg_decode(haddr);
		acc       = hsel && htrans[1] && hready && (hsize == HSIZE_WORD);
		is_async  = !s.mode_reg[MODE_SYNC_SEL];
		ext_clk   = s.ctrl_reg[CTRL_CLK_SRC_SEL_HI];
		rise      = s.sck_s2 && !s.sck_d;
		fall      = !s.sck_s2 && s.sck_d;
		int_tick  = (s.pre_cnt == s.brate);
		clk_run   = (s.tx_st != TX_IDLE) || s.ctrl_reg[CTRL_RX_ENABLE];
		tick      = is_async && (ext_clk ? rise : int_tick);
		shift_ev  = !is_async && (ext_clk ? fall
			: (int_tick && clk_run && s.clk_cnt == TICK_LAST));
		sample_ev = !is_async && (ext_clk ? rise
			: (int_tick && clk_run && s.clk_cnt == TICK_MID));
		tx_step   = is_async ? (tick && s.tx_tick == TICK_LAST) : shift_ev;
		rx_samp   = is_async ? (tick && s.rx_tick == TICK_LAST) : sample_ev;
		mp_on     = is_async && s.mode_reg[MODE_ADDR_FRAME];
		blocked   = s.overrun_err || s.framing_err || s.parity_err;
		rx_byte   = {s.rxd_s2, s.rx_shift_reg[7:1]};
		next_s    = s;

		// Pin synchronisers
		next_s.rxd_s1 = rxd;
		next_s.rxd_s2 = s.rxd_s1;
		next_s.sck_s1 = sck_in;
		next_s.sck_s2 = s.sck_s1;
		next_s.sck_d  = s.sck_s2;

		// Data phase of a write
		if (s.wr_pend)
		begin
			if (s.wr_idx == IDX_MODE)
				next_s.mode_reg = hwdata[7:0];
			else if (s.wr_idx == IDX_BRATE)
				next_s.brate = hwdata[7:0];
			else if (s.wr_idx == IDX_CTRL)
				next_s.ctrl_reg = hwdata[7:0];
			else if (s.wr_idx == IDX_TXDATA)
				next_s.tx_hold_reg = hwdata[7:0];
			else if (s.wr_idx == IDX_STATUS)
			begin
				// Zero clears a flag only after it was read as one, except the transmit address bit, which takes the written value
				if (!hwdata[ST_TX_BUF_EMPTY] && s.seen_tx_empty)
				begin
					next_s.tx_buf_empty = 1'b0;
					next_s.tx_complete  = 1'b0;
				end
				if (!hwdata[ST_RX_BUF_FULL] && s.seen_rx_full)
					next_s.rx_buf_full = 1'b0;
				if (!hwdata[ST_OVERRUN_ERR] && s.seen_overrun)
					next_s.overrun_err = 1'b0;
				if (!hwdata[ST_FRAMING_ERR] && s.seen_framing)
					next_s.framing_err = 1'b0;
				if (!hwdata[ST_PARITY_ERR] && s.seen_parity)
					next_s.parity_err = 1'b0;
				next_s.tx_addr_bit = hwdata[ST_TX_ADDR_BIT];
			end
		end

		// Address phase
		next_s.wr_pend = 1'b0;
		if (acc)
		begin
			if (hwrite)
			begin
				next_s.wr_pend = dec[3];
				next_s.wr_idx  = dec[2:0];
			end
			else
			begin
				next_s.hrdata = {24'h00_0000, dec[3] ? rd_byte(s, dec[2:0]) : 8'h00};
				if (dec[3] && dec[2:0] == IDX_STATUS)
				begin
					next_s.seen_tx_empty = s.seen_tx_empty || s.tx_buf_empty;
					next_s.seen_rx_full  = s.seen_rx_full || s.rx_buf_full;
					next_s.seen_overrun  = s.seen_overrun || s.overrun_err;
					next_s.seen_framing  = s.seen_framing || s.framing_err;
					next_s.seen_parity   = s.seen_parity || s.parity_err;
				end
			end
		end

		// Baud prescaler and serial clock phase
		next_s.pre_cnt = int_tick ? 8'h00 : s.pre_cnt + 8'h01;
		// A stopped sync clock parks so that it restarts on a falling edge
		if (!is_async && !clk_run)
			next_s.clk_cnt = TICK_LAST;
		else if (int_tick)
			next_s.clk_cnt = s.clk_cnt + 4'h1;
		if (tick)
		begin
			next_s.tx_tick = s.tx_tick + 4'h1;
			next_s.rx_tick = s.rx_tick + 4'h1;
		end

		// Transmitter
		if (!s.ctrl_reg[CTRL_TX_ENABLE])
		begin
			next_s.tx_buf_empty = 1'b1;
			next_s.tx_complete  = 1'b1;
			next_s.tx_st        = TX_IDLE;
			next_s.txd          = 1'b1;
		end
		else
		begin
			case (s.tx_st)
				TX_IDLE:
				begin
					if (!next_s.tx_buf_empty)
					begin
						next_s.tx_shift_reg = s.tx_hold_reg;
						next_s.tx_buf_empty = 1'b1;
						next_s.tx_complete  = 1'b0;
						next_s.tx_tick      = 4'h0;
						next_s.txd          = !is_async;
						next_s.tx_st        = TX_START;
					end
				end
				TX_START:
				begin
					if (tx_step)
					begin
						next_s.txd   = s.tx_shift_reg[0];
						next_s.tx_bit = 4'h0;
						next_s.tx_st = TX_DATA;
					end
				end
				TX_DATA:
				begin
					if (tx_step)
					begin
						if (s.tx_bit == BIT_LAST)
						begin
							if (next_s.tx_buf_empty)
								next_s.tx_complete = 1'b1;
							next_s.tx_bit = 4'h0;
							if (!is_async)
							begin
								next_s.txd   = 1'b1;
								next_s.tx_st = TX_IDLE;
							end
							else if (mp_on)
							begin
								next_s.txd   = s.tx_addr_bit;
								next_s.tx_st = TX_ADDR;
							end
							else
							begin
								next_s.txd   = 1'b1;
								next_s.tx_st = TX_STOP;
							end
						end
						else
						begin
							next_s.tx_shift_reg = {1'b1, s.tx_shift_reg[7:1]};
							next_s.txd          = s.tx_shift_reg[1];
							next_s.tx_bit       = s.tx_bit + 4'h1;
						end
					end
				end
				TX_ADDR:
				begin
					if (tx_step)
					begin
						next_s.txd   = 1'b1;
						next_s.tx_st = TX_STOP;
					end
				end
				TX_STOP:
				begin
					if (tx_step)
					begin
						if (s.mode_reg[MODE_TWO_STOP] && s.tx_bit == 4'h0)
							next_s.tx_bit = 4'h1;
						else
							next_s.tx_st = TX_IDLE;
					end
				end
				default:
					next_s.tx_st = TX_IDLE;
			endcase
		end

		// Receiver; disabling it leaves every flag as it was
		if (!s.ctrl_reg[CTRL_RX_ENABLE])
			next_s.rx_st = RX_IDLE;
		else
		begin
			case (s.rx_st)
				RX_IDLE:
				begin
					if (is_async && !blocked && !s.rxd_s2)
					begin
						next_s.rx_tick = 4'h0;
						next_s.rx_st   = RX_START;
					end
					else if (!is_async && !blocked && sample_ev)
					begin
						next_s.rx_shift_reg = rx_byte;
						next_s.rx_bit       = 4'h1;
						next_s.rx_st        = RX_DATA;
					end
				end
				RX_START:
				begin
					if (tick && s.rx_tick == TICK_MID)
					begin
						next_s.rx_tick = 4'h0;
						next_s.rx_bit  = 4'h0;
						next_s.rx_st   = s.rxd_s2 ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA:
				begin
					if (rx_samp)
					begin
						next_s.rx_shift_reg = rx_byte;
						next_s.rx_bit       = s.rx_bit + 4'h1;
						if (s.rx_bit == BIT_LAST)
						begin
							if (!is_async)
							begin
								next_s       = rx_finish(next_s, rx_byte, 1'b1, 1'b0, 1'b0);
								next_s.rx_st = RX_IDLE;
							end
							else
								next_s.rx_st = mp_on ? RX_ADDR : RX_STOP;
						end
					end
				end
				RX_ADDR:
				begin
					if (rx_samp)
					begin
						next_s.rx_mp = s.rxd_s2;
						next_s.rx_st = RX_STOP;
					end
				end
				RX_STOP:
				begin
					if (rx_samp)
					begin
						next_s = rx_finish(next_s, s.rx_shift_reg, s.rxd_s2,
							s.rx_mp, mp_on);
						next_s.rx_st = RX_IDLE;
					end
				end
				default:
					next_s.rx_st = RX_IDLE;
			endcase
		end

		// Sync pin clock idles high unless a shifter runs next cycle
		if (!is_async && next_s.tx_st == TX_IDLE && !next_s.ctrl_reg[CTRL_RX_ENABLE])
			next_s.sck_out = 1'b1;
		else
			next_s.sck_out = next_s.clk_cnt[3];

		// Read-seen marks die with their flag
		if (!next_s.tx_buf_empty)
			next_s.seen_tx_empty = 1'b0;
		if (!next_s.rx_buf_full)
			next_s.seen_rx_full = 1'b0;
		if (!next_s.overrun_err)
			next_s.seen_overrun = 1'b0;
		if (!next_s.framing_err)
			next_s.seen_framing = 1'b0;
		if (!next_s.parity_err)
			next_s.seen_parity = 1'b0;

		// Standby returns everything to reset values
		if (standby)
			next_s = STATE_RESET;
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s <= STATE_RESET;
		else
			s <= next_s;
	end

	// Bus answer: zero wait, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = s.hrdata;

	// Serial pins
	assign txd     = s.txd;
	assign sck_out = s.sck_out;
	// Clock pin direction by clock select and mode
	assign sck_oe  = !s.ctrl_reg[CTRL_CLK_SRC_SEL_HI]
		&& (s.mode_reg[MODE_SYNC_SEL] || s.ctrl_reg[CTRL_CLK_SRC_SEL_LO]);

	// Interrupt request levels
	assign tx_empty_irq = s.ctrl_reg[CTRL_TX_EMPTY_IRQ_EN] && s.tx_buf_empty;
	assign rx_full_irq  = s.ctrl_reg[CTRL_RX_IRQ_EN] && s.rx_buf_full;
	assign rx_error_irq = s.ctrl_reg[CTRL_RX_IRQ_EN]
		&& (s.overrun_err || s.framing_err || s.parity_err);
	assign tx_done_irq  = s.ctrl_reg[CTRL_TX_DONE_IRQ_EN] && s.tx_complete;

endmodule

`default_nettype wire

// File: verification/serial_port_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module serial_port_ctrl_checker
	import serial_port_pkg::*;
(
	// Clock, reset and bus
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        standby,
	// Watched outputs
	input wire logic        sck_oe,
	input wire logic        tx_empty_irq,
	input wire logic        rx_full_irq,
	input wire logic        rx_error_irq,
	input wire logic        tx_done_irq
);
	logic        wr_ph;
	logic [31:0] wr_a;
	logic [7:0]  ctl;
	logic        sync_m;

	// Shadow of control and mode writes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_ph <= 1'b0;
			wr_a <= '0;
			ctl <= '0;
			sync_m <= 1'b0;
		end
		else if (standby)
		begin
			wr_ph <= 1'b0;
			ctl <= '0;
			sync_m <= 1'b0;
		end
		else
		begin
			wr_ph <= hsel && htrans[1] && hready && hwrite && hsize == HSIZE_WORD;
			wr_a <= haddr;
			if (wr_ph && wr_a == OFS_CTRL)
				ctl <= hwdata[7:0];
			if (wr_ph && wr_a == OFS_MODE)
				sync_m <= hwdata[MODE_SYNC_SEL];
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	chk_txe_gate: assert property (!ctl[7] |-> !tx_empty_irq)
		else $error("tx empty irq while gated");
	chk_rx_gate: assert property (!ctl[6] |-> !rx_full_irq && !rx_error_irq)
		else $error("rx irq while gated");
	chk_done_gate: assert property (!ctl[2] |-> !tx_done_irq)
		else $error("tx done irq while gated");
	chk_txe_held: assert property (ctl[7] && !ctl[5] && !$past(ctl[5]) |-> tx_empty_irq)
		else $error("tx empty not held while tx off");
	chk_done_empty: assert property (tx_done_irq && ctl[7] |-> tx_empty_irq)
		else $error("tx done without tx empty");
	chk_sck_dir: assert property (sck_oe == (!ctl[1] && (ctl[0] || sync_m)))
		else $error("clock pin direction wrong");
	chk_rx_keep: assert property ($fell(ctl[4]) && $stable(ctl[6])
		|-> $stable(rx_full_irq) && $stable(rx_error_irq))
		else $error("rx flags moved on rx disable");
	chk_stby_clear: assert property (standby |=> !(tx_empty_irq || rx_full_irq
		|| rx_error_irq || tx_done_irq || sck_oe))
		else $error("standby left outputs active");

	// Main scenarios reached
	cover property (tx_done_irq);
	cover property (rx_full_irq);
	cover property (rx_error_irq);
endmodule
`default_nettype wire

// File: verification/serial_line_model.sv
`timescale 1ns/10ps
`default_nettype none
module serial_line_model (
	// Clock source control
	input wire logic run,
	// Serial lines
	output logic     ext_clk,
	output logic     rxd,
	input wire logic txd,
	input wire logic sck
);
	initial
	begin
		ext_clk = 1'b1;
		rxd = 1'b1;
	end

	// Baud source at sixteen bit-rate ticks per bit, high when stopped
	always #400 ext_clk = run ? ~ext_clk : 1'b1;

	task automatic ticks(input int n);
		repeat (n) @(posedge ext_clk);
	endtask

	// Start, data LSB first, then address and stop, or stop and an idle bit
	task automatic send(input logic [7:0] d, input logic mp, input logic use_mp, input logic stp);
		logic [10:0] f;
		f = use_mp ? {stp, mp, d, 1'b0} : {1'b1, stp, d, 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			rxd = f[i];
			ticks(16);
		end
		rxd = 1'b1;
	endtask

	// Sample each bit in its middle
	task automatic recv(output logic [7:0] d);
		@(negedge txd);
		ticks(8);
		for (int i = 0; i < 8; i++)
		begin
			ticks(16);
			d[i] = txd;
		end
		ticks(16);
	endtask

	// Synchronous mode: take each bit on a rising pin clock
	task automatic srecv(output logic [7:0] d);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge sck);
			d[i] = txd;
		end
	endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	import serial_port_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, standby, link_on;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, rxd, txd, sck_in, sck_out, sck_oe, ext_clk;
	logic        tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq;
	logic [7:0]  d;
	int          n_errors, n_checks;
	time         t0;

	// Clock pin level from both drivers
	assign sck_in = sck_oe ? sck_out : ext_clk;

	serial_port_ctrl serial_port_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.standby(standby), .rxd(rxd), .txd(txd), .sck_in(sck_in), .sck_out(sck_out),
		.sck_oe(sck_oe), .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq),
		.rx_error_irq(rx_error_irq), .tx_done_irq(tx_done_irq));
	serial_line_model serial_line_model_i (.run(link_on), .ext_clk(ext_clk), .rxd(rxd),
		.txd(txd), .sck(sck_in));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One AHB single transfer, address then data phase
	task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] v);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		hsel <= 1'b1;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, v};
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	task automatic wr(input logic [31:0] a, input logic [7:0] v);
		xfer(a, 1'b1, v);
		@(posedge hclk);
	endtask

	task automatic rd(input logic [31:0] a, input logic [7:0] e, input string nm);
		xfer(a, 1'b0, 8'h00);
		chk(nm, {24'h0, e}, hrdata);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	initial
	begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	// Watchdog
	initial
	begin
		#3000000;
		n_errors++;
		end_of_test;
	end

	initial
	begin
		hresetn = 1'b0;
		{hsel, hwrite, standby, link_on, haddr, hwdata, htrans} = '0;
		hsize = HSIZE_WORD;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(OFS_CTRL, 8'h00, "ctrl reset");
		rd(OFS_STATUS, 8'h84, "status reset");
		rd(32'h18, 8'h00, "unmapped");
		wr(OFS_CTRL, 8'hA5);
		rd(OFS_CTRL, 8'hA5, "ctrl rw");
		// Clock pin direction for each mode and select
		for (int m = 0; m < 2; m++)
			for (int c = 0; c < 4; c++)
			begin
				wr(OFS_MODE, {m[0], 7'h0});
				wr(OFS_CTRL, {6'h0, c[1:0]});
				chk("sck_oe", {31'h0, !c[1] && (c[0] || m[0])}, {31'h0, sck_oe});
			end
		// Async clock out: sixteen ticks of two cycles a period
		wr(OFS_MODE, 8'h00);
		wr(OFS_BRATE, 8'h01);
		wr(OFS_CTRL, 8'h01);
		@(posedge sck_out);
		t0 = $time;
		@(posedge sck_out);
		chk("sck period", 32'd3200, 32'($time - t0));
		// Synchronous transmit on the internal clock
		wr(OFS_CTRL, 8'h00);
		wr(OFS_MODE, 8'h80);
		wr(OFS_CTRL, 8'h20);
		wr(OFS_TXDATA, 8'hC3);
		fork
			serial_line_model_i.srecv(d);
			begin
				rd(OFS_STATUS, 8'h84, "status");
				wr(OFS_STATUS, 8'h00);
			end
		join
		chk("sync char", 8'hC3, {24'h0, d});
		// Transmit held off while disabled
		wr(OFS_CTRL, 8'h80);
		wr(OFS_MODE, 8'h00);
		wr(OFS_TXDATA, 8'h5A);
		rd(OFS_STATUS, 8'h84, "status");
		wr(OFS_STATUS, 8'h00);
		rd(OFS_STATUS, 8'h84, "empty held");
		chk("txd idle", 1, {31'h0, txd});
		// Transmit on the external clock, twice
		link_on <= 1'b1;
		wr(OFS_CTRL, 8'hA6);
		fork
			serial_line_model_i.recv(d);
			begin
				rd(OFS_STATUS, 8'h84, "status");
				wr(OFS_STATUS, 8'h00);
			end
		join
		chk("tx char", 8'h5A, {24'h0, d});
		chk("done irq", 1, {31'h0, tx_done_irq});
		chk("empty irq", 1, {31'h0, tx_empty_irq});
		wr(OFS_CTRL, 8'h26);
		chk("empty irq off", 0, {31'h0, tx_empty_irq});
		fork
			serial_line_model_i.recv(d);
			begin
				rd(OFS_STATUS, 8'h84, "status");
				wr(OFS_STATUS, 8'h00);
				chk("done by flag", 0, {31'h0, tx_done_irq});
			end
		join
		chk("tx char 2", 8'h5A, {24'h0, d});
		wr(OFS_CTRL, 8'h22);
		chk("done by enable", 0, {31'h0, tx_done_irq});
		// Receive with address wait ignored in plain frames
		wr(OFS_CTRL, 8'h5A);
		serial_line_model_i.send(8'h3C, 1'b0, 1'b0, 1'b1);
		chk("rx irq", 1, {31'h0, rx_full_irq});
		rd(OFS_RXDATA, 8'h3C, "rx data");
		wr(OFS_CTRL, 8'h4A);
		chk("rx kept", 1, {31'h0, rx_full_irq});
		rd(OFS_STATUS, 8'hC4, "status full");
		wr(OFS_STATUS, 8'h84);
		chk("rx irq clear", 0, {31'h0, rx_full_irq});
		// Framing error
		wr(OFS_CTRL, 8'h52);
		serial_line_model_i.send(8'h77, 1'b0, 1'b0, 1'b0);
		chk("err irq", 1, {31'h0, rx_error_irq});
		chk("no full", 0, {31'h0, rx_full_irq});
		wr(OFS_CTRL, 8'h02);
		chk("err irq off", 0, {31'h0, rx_error_irq});
		rd(OFS_STATUS, 8'h94, "status fer");
		wr(OFS_STATUS, 8'h84);
		rd(OFS_STATUS, 8'h84, "fer clear");
		// Address wait in address frames
		wr(OFS_MODE, 8'h04);
		wr(OFS_CTRL, 8'h5A);
		serial_line_model_i.send(8'h11, 1'b0, 1'b1, 1'b1);
		chk("skipped", 0, {31'h0, rx_full_irq});
		serial_line_model_i.send(8'h22, 1'b1, 1'b1, 1'b1);
		chk("addr rx", 1, {31'h0, rx_full_irq});
		rd(OFS_CTRL, 8'h52, "wait cleared");
		rd(OFS_STATUS, 8'hC6, "addr bit");
		rd(OFS_RXDATA, 8'h22, "addr data");
		// Standby clears the control register
		link_on <= 1'b0;
		standby <= 1'b1;
		repeat (2) @(posedge hclk);
		standby <= 1'b0;
		@(posedge hclk);
		rd(OFS_CTRL, 8'h00, "ctrl standby");
		rd(OFS_STATUS, 8'h84, "status standby");
		end_of_test;
	end
endmodule

bind serial_port_ctrl serial_port_ctrl_checker serial_port_ctrl_checker_i (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hwdata(hwdata), .hready(hready), .standby(standby), .sck_oe(sck_oe),
	.tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq),
	.tx_done_irq(tx_done_irq));
`default_nettype wire
